// ===== logic/lcts_top.sv
// Loss-of-channel trip supervisor: trip gating, indicators, alarm and transmit source
`timescale 1ns/1ns
// How it works
// - Block response: no trip, trip indicators stay off while channels are lost, except on overcurrent with the control input set.
// - Allow response: overcurrent during channel loss sets both trip flags.
// - Delayed response: trip only once the overcurrent delay has expired.
// - Delayed response: differential trip signal follows overcurrent at once.
// - Trip indicators latch; reset clears them only after current is gone.
// - Unblock: on loss with trip active, drop 45 ms, trip 105 ms, then block.
// - Unblock: after the window ends the indicator stays off while lost.
// - Reclose option with breaker closed: re-trip on overcurrent within 2.5 s.
// - Unblock-then-delay: window then delayed trip; short delay trips steadily.
// - Reset during persisting fault current leaves trip indicators set.
// - Overcurrent-control input forces overcurrent tripping even when blocked.
// - Transmit source: modulated tone, off, steady tone, or keyed modulation.
// - Healthy channels: differential condition drives relay and indicator.
// - Trip-control switch closed during trip sets trip one and two flags.
// - Channel declared lost and alarm raised 2.5 s after signal disappears.
module lcts_top
  import lcts_pkg::*;
#(
  parameter int NUM_CH      = 2,
  parameter int TICK_CYCLES = CYCLES_PER_MS,
  parameter int TONE_HALF   = TONE_HALF_CYCLES,
  parameter int MOD_HALF    = MOD_HALF_CYCLES
)(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  // Field inputs
  input  wire logic [NUM_CH-1:0] chanPresent,
  input  wire logic              overcurrent,
  input  wire logic              diffCondition,
  input  wire logic              overcurrentControlInput,
  input  wire logic              breakerAuxContact,
  input  wire logic              tripCtlSwitch,
  input  wire logic              transferTripKey,
  input  wire logic              indicatorReset,
  // Static options
  input  wire lcts_cfg_t         cfg,
  // Outputs
  output lcts_ind_t              ind,
  output logic                   mainTripRelay,
  output logic                   diffTripSignal,
  output logic                   overcurrentDelayDone,
  output logic                   alarmRelay,
  output logic                   channelLost,
  output logic                   modulatedTxOut
);

  localparam int PIN_W = NUM_CH + 7;

  // Two-stage synchronisers for everything off the pins
  logic [PIN_W-1:0] pinA;
  logic [PIN_W-1:0] pinB;
  lcts_cfg_t        cfgA;
  lcts_cfg_t        cfgB;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pinA <= {{NUM_CH{1'b1}}, 7'h00};
      pinB <= {{NUM_CH{1'b1}}, 7'h00};
      cfgA <= '0;
      cfgB <= '0;
    end else if (ce) begin
      pinA <= {chanPresent, overcurrent, diffCondition, overcurrentControlInput, breakerAuxContact,
               tripCtlSwitch, transferTripKey, indicatorReset};
      pinB <= pinA;
      cfgA <= cfg;
      cfgB <= cfgA;
    end
  end

  logic [NUM_CH-1:0] present;
  logic              oc;
  logic              diffC;
  logic              ocCtl;
  logic              breakerClosed;
  logic              tripSw;
  logic              ttKey;
  logic              rstPress;
  lcts_resp_t        resp;

  assign present       = pinB[PIN_W-1:7];
  assign oc            = pinB[6];
  assign diffC         = pinB[5];
  assign ocCtl         = pinB[4];
  assign breakerClosed = pinB[3];
  assign tripSw        = pinB[2];
  assign ttKey         = pinB[1];
  assign rstPress      = pinB[0];
  assign resp          = cfgB.channelLossResponseSelect;

  // Millisecond tick, tone and modulation dividers
  logic [CNT_W-1:0] tickCnt;
  logic [CNT_W-1:0] toneCnt;
  logic [CNT_W-1:0] modCnt;
  logic             msTick;
  logic             tone;
  logic             modPhase;
  logic [CNT_W-1:0] next_tickCnt;
  logic [CNT_W-1:0] next_toneCnt;
  logic [CNT_W-1:0] next_modCnt;
  logic             next_msTick;
  logic             next_tone;
  logic             next_modPhase;
  logic             next_tx;

  always_comb begin
    next_msTick   = (tickCnt == CNT_W'(TICK_CYCLES - 1));
    next_tickCnt  = next_msTick ? '0 : tickCnt + CNT_W'(1);
    next_toneCnt  = (toneCnt == CNT_W'(TONE_HALF - 1)) ? '0 : toneCnt + CNT_W'(1);
    next_tone     = (toneCnt == CNT_W'(TONE_HALF - 1)) ? ~tone : tone;
    next_modCnt   = (modCnt == CNT_W'(MOD_HALF - 1)) ? '0 : modCnt + CNT_W'(1);
    next_modPhase = (modCnt == CNT_W'(MOD_HALF - 1)) ? ~modPhase : modPhase;
    case (cfgB.controlChannelOption)
      CCO_MODULATED:         next_tx = tone & modPhase;
      CARRIER_OFF_OPTION:    next_tx = 1'b0;
      STEADY_CARRIER_OPTION: next_tx = tone;
      TRANSFER_KEYED_OPTION: next_tx = ttKey ? (tone & modPhase) : tone;
      default:               next_tx = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt        <= '0;
      toneCnt        <= '0;
      modCnt         <= '0;
      msTick         <= 1'b0;
      tone           <= 1'b0;
      modPhase       <= 1'b0;
      modulatedTxOut <= 1'b0;
    end else if (ce) begin
      tickCnt        <= next_tickCnt;
      toneCnt        <= next_toneCnt;
      modCnt         <= next_modCnt;
      msTick         <= next_msTick;
      tone           <= next_tone;
      modPhase       <= next_modPhase;
      modulatedTxOut <= next_tx;
    end
  end

  // Channel state: down at once for trip gating, declared lost after the alarm delay
  logic              chanDown;
  logic              chanDownD;
  logic              lostRise;
  logic [NUM_CH-1:0] lossDone;
  logic              delayDone;
  logic              recloseDone;

  assign chanDown = |(~present);
  assign lostRise = chanDown & ~chanDownD;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_loss
    lcts_timer u_loss (
      .core_clk (core_clk),
      .rstn     (rstn),
      .ce       (ce),
      .msTick   (msTick),
      .run      (~present[i]),
      .limit    (TMR_W'(LOSS_ALARM_MS)),
      .done     (lossDone[i])
    );
  end

  lcts_timer u_delay (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ce       (ce),
    .msTick   (msTick),
    .run      (chanDown & oc),
    .limit    (cfgB.delaySetting),
    .done     (delayDone)
  );

  lcts_timer u_reclose (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ce       (ce),
    .msTick   (msTick),
    .run      (chanDown),
    .limit    (TMR_W'(RECLOSE_MS)),
    .done     (recloseDone)
  );

  // Unblock window sequencer
  lcts_win_t        winState;
  logic [WIN_W-1:0] winMs;
  lcts_win_t        next_winState;
  logic [WIN_W-1:0] next_winMs;
  logic             unblockMode;

  assign unblockMode = (resp == RESPONSE_UNBLOCK) || (resp == RESPONSE_UNBLOCK_RECLOSE) ||
                       (resp == RESPONSE_UNBLOCK_THEN_DELAY);

  always_comb begin
    next_winState = winState;
    next_winMs    = msTick ? winMs + WIN_W'(1) : winMs;
    case (winState)
      WIN_IDLE: begin
        next_winMs = '0;
        if (lostRise && unblockMode) begin
          next_winState = mainTripRelay ? WIN_GAP : WIN_DONE;
        end
      end
      WIN_GAP: begin
        if (msTick && winMs == WIN_W'(WIN_GAP_MS - 1)) begin
          next_winState = WIN_OPEN;
          next_winMs    = '0;
        end
      end
      WIN_OPEN: begin
        if (msTick && winMs == WIN_W'(WIN_OPEN_MS - 1)) begin
          next_winState = WIN_DONE;
          next_winMs    = '0;
        end
      end
      WIN_DONE: next_winMs = '0;
      default:  next_winState = WIN_IDLE;
    endcase
    if (!chanDown) begin
      next_winState = WIN_IDLE;
      next_winMs    = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      winState  <= WIN_IDLE;
      winMs     <= '0;
      chanDownD <= 1'b0;
    end else if (ce) begin
      winState  <= next_winState;
      winMs     <= next_winMs;
      chanDownD <= chanDown;
    end
  end

  // Trip decision and latched indicators
  logic      tripReq;
  logic      winOpen;
  logic      recloseWin;
  logic      clearOk;
  lcts_ind_t next_ind;

  assign winOpen    = (winState == WIN_OPEN) || (winState == WIN_IDLE);
  assign recloseWin = cfgB.recloseEnableOption && !cfgB.tripDisableOption && breakerClosed &&
                      !recloseDone && (winState == WIN_DONE);
  // A reset press only counts once fault current is gone
  assign clearOk    = rstPress && !oc;

  always_comb begin
    tripReq = 1'b0;
    if (!chanDown) begin
      tripReq = diffC;
    end else begin
      case (resp)
        RESPONSE_BLOCK:           tripReq = 1'b0;
        RESPONSE_ALLOW:           tripReq = oc;
        RESPONSE_DELAYED:         tripReq = oc && delayDone;
        RESPONSE_UNBLOCK:         tripReq = oc && winOpen;
        RESPONSE_UNBLOCK_RECLOSE: tripReq = oc && (winOpen || recloseWin);
        RESPONSE_UNBLOCK_THEN_DELAY: begin
          // Short delay would overlap the window, so hold the trip steady
          if (cfgB.delaySetting <= TMR_W'(WIN_MS)) begin
            tripReq = oc;
          end else begin
            tripReq = oc && ((winState == WIN_GAP) ? 1'b0 : (winOpen || delayDone));
          end
        end
        default:                  tripReq = 1'b0;
      endcase
      if (ocCtl && oc) begin
        tripReq = 1'b1;
      end
    end
    // Set wins over clear on every latched flag
    next_ind.differentialTripFlag       = tripReq ||
                                          (ind.differentialTripFlag && !clearOk);
    next_ind.overcurrentUnblockTripFlag = (tripReq && chanDown) ||
                                          (ind.overcurrentUnblockTripFlag && !clearOk);
    next_ind.tripOneFlag                = (tripReq && tripSw) || (ind.tripOneFlag && !clearOk);
    next_ind.tripTwoFlag                = (tripReq && tripSw) || (ind.tripTwoFlag && !clearOk);
    next_ind.channelAlarm               = (|lossDone) ||
                                          (ind.channelAlarm && !(rstPress && !chanDown));
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ind                  <= '0;
      mainTripRelay        <= RST_FLAG;
      diffTripSignal       <= RST_FLAG;
      overcurrentDelayDone <= RST_FLAG;
      alarmRelay           <= RST_FLAG;
      channelLost          <= RST_FLAG;
    end else if (ce) begin
      ind                  <= next_ind;
      mainTripRelay        <= tripReq;
      diffTripSignal       <= chanDown ? oc : diffC;
      overcurrentDelayDone <= delayDone;
      alarmRelay           <= next_ind.channelAlarm;
      channelLost          <= |lossDone;
    end
  end

endmodule : lcts_top

// ===== logic/lcts_pkg.sv
// Shared types and constants of the loss-of-channel trip supervisor
package lcts_pkg;

  // Clock and time units
  localparam int CLK_PERIOD_NS    = 50;
  localparam int MS_NS            = 1000000;
  localparam int CYCLES_PER_MS    = MS_NS / CLK_PERIOD_NS;
  localparam int SEC_NS           = 1000000000;

  // Transmit tone and its low-frequency modulation
  localparam int TONE_HZ          = 1700;
  localparam int TONE_HALF_CYCLES = SEC_NS / (CLK_PERIOD_NS * 2 * TONE_HZ);
  localparam int MOD_HZ           = 60;
  localparam int MOD_HALF_CYCLES  = SEC_NS / (CLK_PERIOD_NS * 2 * MOD_HZ);

  // Millisecond timings
  localparam int LOSS_ALARM_MS    = 2500;
  localparam int RECLOSE_MS       = 2500;
  localparam int WIN_GAP_MS       = 45;
  localparam int WIN_OPEN_MS      = 105;
  localparam int WIN_MS           = WIN_GAP_MS + WIN_OPEN_MS;

  // Counter widths
  localparam int CNT_W            = 18;
  localparam int TMR_W            = 16;
  localparam int WIN_W            = 8;

  // Reset values
  localparam logic RST_FLAG       = 1'b0;

  typedef enum logic [2:0] {
    RESPONSE_BLOCK,
    RESPONSE_ALLOW,
    RESPONSE_DELAYED,
    RESPONSE_UNBLOCK,
    RESPONSE_UNBLOCK_RECLOSE,
    RESPONSE_UNBLOCK_THEN_DELAY
  } lcts_resp_t;

  typedef enum logic [1:0] {
    CCO_MODULATED,
    CARRIER_OFF_OPTION,
    STEADY_CARRIER_OPTION,
    TRANSFER_KEYED_OPTION
  } lcts_cco_t;

  typedef enum logic [1:0] {
    WIN_IDLE,
    WIN_GAP,
    WIN_OPEN,
    WIN_DONE
  } lcts_win_t;

  typedef struct packed {
    lcts_resp_t              channelLossResponseSelect;
    logic                    recloseEnableOption;
    logic                    tripDisableOption;
    lcts_cco_t               controlChannelOption;
    logic [TMR_W-1:0]        delaySetting;
  } lcts_cfg_t;

  typedef struct packed {
    logic overcurrentUnblockTripFlag;
    logic differentialTripFlag;
    logic tripOneFlag;
    logic tripTwoFlag;
    logic channelAlarm;
  } lcts_ind_t;

endpackage : lcts_pkg

// ===== logic/lcts_timer.sv
// Millisecond timer that reports when a running interval reaches its limit
`timescale 1ns/1ns
module lcts_timer
  import lcts_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  // Control
  input  wire logic             msTick,
  input  wire logic             run,
  input  wire logic [TMR_W-1:0] limit,
  // Status
  output logic                  done
);

  logic [TMR_W-1:0] count;
  logic [TMR_W-1:0] next_count;
  logic             next_done;

  // Dropping run restarts the interval from zero
  always_comb begin
    next_count = '0;
    if (run) begin
      next_count = (msTick && count < limit) ? count + TMR_W'(1) : count;
    end
    next_done = run && (next_count >= limit);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      done  <= 1'b0;
    end else if (ce) begin
      count <= next_count;
      done  <= next_done;
    end
  end

endmodule : lcts_timer

// ===== sim/lcts_props.sv
// Checker of trip gating, indicators and transmit source at the top ports
`timescale 1ns/1ns
module lcts_props
  import lcts_pkg::*;
#(
  parameter int NUM_CH = 2
)(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rstn,
  // Field inputs and options
  input wire logic [NUM_CH-1:0] chanPresent,
  input wire logic              overcurrent,
  input wire logic              diffCondition,
  input wire logic              overcurrentControlInput,
  input wire logic              tripCtlSwitch,
  input wire logic              indicatorReset,
  input wire lcts_cfg_t         cfg,
  // Outputs
  input wire lcts_ind_t         ind,
  input wire logic              mainTripRelay,
  input wire logic              diffTripSignal,
  input wire logic              alarmRelay,
  input wire logic              channelLost,
  input wire logic              modulatedTxOut
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire logic chanDown = !(&chanPresent);
  wire logic isBlock  = cfg.channelLossResponseSelect == RESPONSE_BLOCK;
  wire logic isAllow  = cfg.channelLossResponseSelect == RESPONSE_ALLOW;
  // Long enough for two sync stages plus the output flop
  sequence s_lost_oc;
    (chanDown && overcurrent)[*5];
  endsequence
  sequence s_healthy_diff;
    (!chanDown && diffCondition)[*5];
  endsequence
  a_block_no_trip: assert property ((isBlock && chanDown && !overcurrentControlInput)[*5] |-> !mainTripRelay)
    else $error("trip seen while blocked");
  a_allow_both_flags: assert property ((isAllow && chanDown && overcurrent)[*5]
    |-> mainTripRelay && ind.differentialTripFlag && ind.overcurrentUnblockTripFlag)
    else $error("allow trip missing");
  a_diff_signal_now: assert property (s_lost_oc |-> diffTripSignal)
    else $error("differential trip signal late");
  a_flag_clear_cause: assert property ($fell(ind.differentialTripFlag)
    |-> $past(indicatorReset, 3) && !$past(overcurrent, 3))
    else $error("trip flag cleared without reset");
  a_occ_forces_trip: assert property ((chanDown && overcurrent && overcurrentControlInput)[*5] |-> mainTripRelay)
    else $error("control input trip missing");
  a_carrier_off: assert property ((cfg.controlChannelOption == CARRIER_OFF_OPTION)[*5] |-> !modulatedTxOut)
    else $error("transmit active while off");
  a_healthy_trip: assert property (s_healthy_diff |-> mainTripRelay && ind.differentialTripFlag)
    else $error("healthy differential trip missing");
  a_switch_flags: assert property ((tripCtlSwitch && diffCondition && !chanDown)[*5]
    |-> ind.tripOneFlag && ind.tripTwoFlag)
    else $error("trip one or two flag missing");
  a_loss_alarm: assert property ($rose(channelLost) |-> ##[0:2] ind.channelAlarm)
    else $error("alarm not raised on loss");
  a_alarm_mirror: assert property (alarmRelay == ind.channelAlarm)
    else $error("alarm relay differs from alarm flag");
  a_alarm_clear: assert property ($fell(ind.channelAlarm)
    |-> $past(indicatorReset, 3) && $past(&chanPresent, 3))
    else $error("alarm cleared without reset");
endmodule : lcts_props

bind lcts_top lcts_props #(.NUM_CH(NUM_CH)) u_props (
  .core_clk(core_clk), .rstn(rstn), .chanPresent(chanPresent), .overcurrent(overcurrent),
  .diffCondition(diffCondition), .overcurrentControlInput(overcurrentControlInput),
  .tripCtlSwitch(tripCtlSwitch), .indicatorReset(indicatorReset), .cfg(cfg), .ind(ind),
  .mainTripRelay(mainTripRelay), .diffTripSignal(diffTripSignal), .alarmRelay(alarmRelay),
  .channelLost(channelLost), .modulatedTxOut(modulatedTxOut));

// ===== sim/lcts_remote_model.sv
// Remote terminal model: received signal presence on each channel
`timescale 1ns/1ns
module lcts_remote_model #(
  parameter int NUM_CH = 2
)(
  // Clock
  input  wire logic              core_clk,
  // Link state commanded by the bench
  input  wire logic [NUM_CH-1:0] linkUp,
  // Receiver presence
  output logic      [NUM_CH-1:0] chanPresent
);
  initial chanPresent = '1;
  // Follows the bench one clock later; the edge that moves it never samples it
  always @(posedge core_clk) begin
    chanPresent <= linkUp;
  end
endmodule : lcts_remote_model

// ===== sim/tb.sv
// Self-checking bench of the loss-of-channel trip supervisor
`timescale 1ns/1ns
module tb;
  import lcts_pkg::*;
  localparam int TK = 10;
  logic       core_clk = 1'b0;
  logic       rstn     = 1'b0;
  logic [1:0] linkUp   = 2'h3;
  logic [1:0] chanPresent;
  logic       oc = 1'b0, dc = 1'b0, occ = 1'b0, brk = 1'b0;
  logic       tsw = 1'b0, key = 1'b0, irst = 1'b0;
  logic       trip, dts, odd, alm, lost, tx;
  lcts_cfg_t  cfg = '0;
  lcts_ind_t  ind;
  int         miscompares = 0, checks = 0, seed = 32'hBA19, n, d, h, e;
  int         expWin[$] = '{45, 105};
  always #25 core_clk = ~core_clk;
  lcts_remote_model #(.NUM_CH(2)) u_remote (.core_clk(core_clk), .linkUp(linkUp), .chanPresent(chanPresent));
  lcts_top #(.NUM_CH(2), .TICK_CYCLES(TK), .TONE_HALF(4), .MOD_HALF(40)) u_dut (
    .core_clk(core_clk), .rstn(rstn), .ce(1'b1), .chanPresent(chanPresent), .overcurrent(oc),
    .diffCondition(dc), .overcurrentControlInput(occ), .breakerAuxContact(brk), .tripCtlSwitch(tsw),
    .transferTripKey(key), .indicatorReset(irst), .cfg(cfg), .ind(ind), .mainTripRelay(trip),
    .diffTripSignal(dts), .overcurrentDelayDone(odd), .alarmRelay(alm), .channelLost(lost),
    .modulatedTxOut(tx));
  task automatic wt(input int c);
    repeat (c) @(negedge core_clk);
  endtask : wt
  task automatic chk_bit(input string nm, input logic x, input logic g);
    checks++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", nm, x, g);
    end
  endtask : chk_bit
  task automatic chk_num(input string nm, input int x, input int g, input int tol);
    checks++;
    if (g < x - tol || g > x + tol) begin
      miscompares++;
      $display("ERROR %s expected %0d seen %0d", nm, x, g);
    end
  endtask : chk_num
  // Counts whole ms until trip (sel 0) or alarm (sel 1) reaches v
  task automatic await_lvl(input int sel, input logic v, input int lim, output int ms);
    int c = 0;
    while ((sel ? alm : trip) !== v && c < lim) begin
      wt(1);
      c++;
    end
    ms = c / TK;
  endtask : await_lvl
  task automatic setm(input lcts_resp_t m);
    cfg.channelLossResponseSelect = m;
    wt(5);
  endtask : setm
  // Reset press only after current is gone, else flags would hold
  task automatic clr;
    oc = 1'b0;
    dc = 1'b0;
    wt(5);
    irst = 1'b1;
    wt(5);
    irst = 1'b0;
    wt(5);
  endtask : clr
  task automatic tally_and_finish;
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #(100000 * 50);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    wt(10);
    rstn = 1'b1;
    wt(5);
    setm(RESPONSE_ALLOW);
    dc = 1'b1;
    tsw = 1'b1;
    wt(5);
    chk_bit("relay", 1'b1, trip);
    chk_bit("diff flag", 1'b1, ind.differentialTripFlag);
    chk_bit("trip one", 1'b1, ind.tripOneFlag);
    chk_bit("trip two", 1'b1, ind.tripTwoFlag);
    tsw = 1'b0;
    clr();
    chk_bit("diff flag", 1'b0, ind.differentialTripFlag);
    setm(RESPONSE_BLOCK);
    linkUp = 2'h0;
    oc = 1'b1;
    await_lvl(1, 1'b1, 30000, n);
    chk_num("alarm ms", 2500, n, 1);
    chk_bit("lost", 1'b1, lost);
    chk_bit("relay", 1'b0, trip);
    chk_bit("oc flag", 1'b0, ind.overcurrentUnblockTripFlag);
    occ = 1'b1;
    wt(5);
    chk_bit("relay", 1'b1, trip);
    occ = 1'b0;
    linkUp = 2'h3;
    wt(5);
    chk_bit("alarm held", 1'b1, alm);
    clr();
    chk_bit("alarm", 1'b0, alm);
    setm(RESPONSE_ALLOW);
    linkUp = 2'h1;
    oc = 1'b1;
    wt(5);
    chk_bit("relay", 1'b1, trip);
    chk_bit("oc flag", 1'b1, ind.overcurrentUnblockTripFlag);
    chk_bit("diff flag", 1'b1, ind.differentialTripFlag);
    irst = 1'b1;
    wt(5);
    irst = 1'b0;
    wt(2);
    chk_bit("oc flag held", 1'b1, ind.overcurrentUnblockTripFlag);
    clr();
    chk_bit("oc flag", 1'b0, ind.overcurrentUnblockTripFlag);
    linkUp = 2'h3;
    d = 10 + ($random(seed) & 31);
    cfg.delaySetting = d[15:0];
    setm(RESPONSE_DELAYED);
    linkUp = 2'h2;
    wt(5);
    oc = 1'b1;
    wt(4);
    chk_bit("diff signal", 1'b1, dts);
    chk_bit("relay early", 1'b0, trip);
    await_lvl(0, 1'b1, 1000, n);
    chk_num("delay ms", d, n, 1);
    chk_bit("delay done", 1'b1, odd);
    clr();
    linkUp = 2'h3;
    setm(RESPONSE_UNBLOCK);
    oc = 1'b1;
    dc = 1'b1;
    wt(5);
    linkUp = 2'h2;
    await_lvl(0, 1'b0, 100, n);
    await_lvl(0, 1'b1, 1000, n);
    chk_num("gap ms", expWin[0], n, 1);
    await_lvl(0, 1'b0, 2000, n);
    chk_num("open ms", expWin[1], n, 1);
    wt(500);
    chk_bit("blocked", 1'b0, trip);
    clr();
    oc = 1'b1;
    wt(20);
    chk_bit("diff flag", 1'b0, ind.differentialTripFlag);
    oc = 1'b0;
    linkUp = 2'h3;
    cfg.recloseEnableOption = 1'b1;
    brk = 1'b1;
    setm(RESPONSE_UNBLOCK_RECLOSE);
    for (int k = 0; k < 2; k++) begin
      oc = 1'b1;
      dc = 1'b1;
      wt(5);
      linkUp = 2'h2;
      wt(200 * TK);
      clr();
      wt((k ? 2400 : 0) * TK);
      oc = 1'b1;
      wt(5);
      chk_bit("reclose trip", k ? 1'b0 : 1'b1, trip);
      chk_bit("reclose flag", k ? 1'b0 : 1'b1, ind.overcurrentUnblockTripFlag);
      linkUp = 2'h3;
      clr();
    end
    brk = 1'b0;
    cfg.recloseEnableOption = 1'b0;
    cfg.delaySetting = 16'h0064;
    setm(RESPONSE_UNBLOCK_THEN_DELAY);
    oc = 1'b1;
    dc = 1'b1;
    wt(5);
    linkUp = 2'h1;
    for (n = 0; n < 300 * TK && trip === 1'b1; n++) wt(1);
    chk_num("steady trip ms", 300, n / TK, 0);
    irst = 1'b1;
    wt(5);
    irst = 1'b0;
    wt(2);
    chk_bit("diff flag held", 1'b1, ind.differentialTripFlag);
    chk_bit("oc flag held", 1'b1, ind.overcurrentUnblockTripFlag);
    clr();
    chk_bit("oc flag", 1'b0, ind.overcurrentUnblockTripFlag);
    linkUp = 2'h3;
    // Long delay: window first, then the delayed trip
    cfg.delaySetting = 16'h0190;
    oc = 1'b1;
    dc = 1'b1;
    wt(5);
    linkUp = 2'h1;
    await_lvl(0, 1'b0, 100, n);
    await_lvl(0, 1'b1, 1000, n);
    chk_num("gap ms", expWin[0], n, 1);
    await_lvl(0, 1'b0, 2000, n);
    chk_num("open ms", expWin[1], n, 1);
    await_lvl(0, 1'b1, 4000, n);
    chk_num("delayed ms", 400 - expWin[0] - expWin[1], n, 1);
    clr();
    linkUp = 2'h3;
    for (int m = 0; m < 5; m++) begin
      cfg.controlChannelOption = lcts_cco_t'(m > 3 ? 3 : m);
      key = (m == 3) ? 1'($random(seed)) : ~key;
      e = (m == 1) ? 0 : (m == 2 || (m > 2 && !key)) ? 80 : 40;
      wt(10);
      h = 0;
      repeat (160) begin
        wt(1);
        h += (tx === 1'b1);
      end
      chk_num("tx highs", e, h, 6);
    end
    tally_and_finish();
  end
endmodule : tb
